/* ede_ctrl.sv */
// data eeprom access control: register file, move steering, page latches, launch
// assumes bus strobes are one cycle wide and synchronous to clk
`timescale 1ns/10ps
`default_nettype none
// Contract
// - eeprom read through data pointer returns array byte when space select set.
// - control bit 1 steers moves to eeprom latches or normal data space.
// - programming starts only on write code 5 then immediately code A.
// - hardware sets busy flag, control bit 0, when programming starts.
// - hardware clears busy flag when programming finishes.
// - software writes never change the busy flag.
// - control bits 3 and 2 are unimplemented; read value is free.
// - reset clears space select and busy flag.
// - write timer value sets programming duration, scaling with oscillator.
// - write timer resets to zero.
// - bytes for another page are dropped; first latched page is kept.
// - array reads are unavailable while busy.
module ede_ctrl #(
  parameter int PRESCALE = ede_pkg::PRESCALE_CYCLES,
  parameter int EE_SIZE = ede_pkg::EE_BYTES,
  parameter int PAGE = ede_pkg::PAGE_BYTES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic xd_rd,
  input wire logic xd_wr,
  input wire logic [15:0] xd_addr,
  input wire logic [7:0] xd_wdata,
  output logic [7:0] xd_rdata,
  output logic xd_rvalid,
  output logic dspace_rd,
  output logic dspace_wr,
  output logic [15:0] dspace_addr,
  output logic [7:0] dspace_wdata,
  output logic program_in_progress,
  output logic eeprom_space_select
);
  import ede_pkg::*;
  localparam int AW = $clog2(EE_SIZE);
  localparam int IW = $clog2(PAGE);

  ede_prog_if prog ();

  logic sel_q, busy_q, armed_q, page_held_q;
  logic [7:0] tim_q;
  logic [AW-1:IW] page_q;
  logic [PAGE-1:0] lat_valid_q;
  logic [7:0] lat_mem [PAGE];
  logic [7:0] mem [EE_SIZE];
  logic [7:0] sfr_rdata_q, xd_rdata_q;
  logic xd_rvalid_q, dspace_rd_q, dspace_wr_q;
  logic [15:0] dspace_addr_q;
  logic [7:0] dspace_wdata_q;
  logic ctl_wr, tim_wr, fire, ee_wr, ee_take, page_match, commit;
  logic [3:0] nib;
  logic [AW-1:0] ee_addr;
  logic [7:0] rd_expect;

  assign ee_addr = xd_addr[AW-1:0];
  assign nib = sfr_wdata[7:LAUNCH_LSB];
  assign ctl_wr = clk_en && sfr_wr && (sfr_addr == ADDR_CTL);
  assign tim_wr = clk_en && sfr_wr && (sfr_addr == ADDR_TIM);
  // a second code while busy is ignored rather than restarting the timer
  assign fire = ctl_wr && armed_q && (nib == LAUNCH_FIRE) && !busy_q;
  assign commit = clk_en && prog.done;
  assign ee_wr = clk_en && xd_wr && sel_q && !busy_q;
  assign page_match = (page_q == ee_addr[AW-1:IW]);
  assign ee_take = ee_wr && (!page_held_q || page_match);
  assign rd_expect = mem[ee_addr];
  assign prog.start = fire;
  assign prog.ticks = tim_q;

  // space select is the only software-writable control bit
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_q <= 1'b0;
    end else if (ctl_wr) begin
      sel_q <= sfr_wdata[CTL_SEL_BIT];
    end
  end

  // launch arming: only the immediately following control write can fire
  always_ff @(posedge clk) begin
    if (rst) begin
      armed_q <= 1'b0;
    end else if (ctl_wr) begin
      armed_q <= (nib == LAUNCH_ARM);
    end
  end

  // busy follows the timer only; the write data bit 0 is never looked at
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else if (fire) begin
      busy_q <= 1'b1;
    end else if (commit) begin
      busy_q <= 1'b0;
    end
  end

  // write timer register
  always_ff @(posedge clk) begin
    if (rst) begin
      tim_q <= TIM_RESET;
    end else if (tim_wr) begin
      tim_q <= sfr_wdata;
    end
  end

  // register read port; bits 7..2 of control read zero
  always_ff @(posedge clk) begin
    if (rst) begin
      sfr_rdata_q <= UNMAPPED_RD;
    end else if (clk_en && sfr_rd) begin
      if (sfr_addr == ADDR_CTL) begin
        sfr_rdata_q <= {6'h00, sel_q, busy_q};
      end else if (sfr_addr == ADDR_TIM) begin
        sfr_rdata_q <= tim_q;
      end else begin
        sfr_rdata_q <= UNMAPPED_RD;
      end
    end
  end

  // column latch bookkeeping: first page wins until programming completes
  always_ff @(posedge clk) begin
    if (rst) begin
      lat_valid_q <= '0;
      page_held_q <= 1'b0;
      page_q <= '0;
    end else if (commit) begin
      lat_valid_q <= '0;
      page_held_q <= 1'b0;
    end else if (ee_take) begin
      lat_valid_q[ee_addr[IW-1:0]] <= 1'b1;
      page_held_q <= 1'b1;
      page_q <= ee_addr[AW-1:IW];
    end
  end

  // latch data needs no reset, validity is tracked separately
  always_ff @(posedge clk) begin
    if (ee_take) begin
      lat_mem[ee_addr[IW-1:0]] <= xd_wdata;
    end
  end

  // array update at the end of programming; only latched bytes change
  always_ff @(posedge clk) begin
    if (commit) begin
      for (int i = 0; i < PAGE; i++) begin
        if (lat_valid_q[i]) begin
          mem[{page_q, IW'(i)}] <= lat_mem[i];
        end
      end
    end
  end

  // external-data read path; a busy array answers a fixed value
  always_ff @(posedge clk) begin
    if (rst) begin
      xd_rdata_q <= 8'h00;
      xd_rvalid_q <= 1'b0;
    end else if (clk_en) begin
      xd_rvalid_q <= xd_rd && sel_q;
      if (xd_rd && sel_q) begin
        xd_rdata_q <= busy_q ? RD_BUSY_VAL : rd_expect;
      end
    end
  end

  // moves steered to ordinary data space
  always_ff @(posedge clk) begin
    if (rst) begin
      dspace_rd_q <= 1'b0;
      dspace_wr_q <= 1'b0;
      dspace_addr_q <= 16'h0000;
      dspace_wdata_q <= 8'h00;
    end else if (clk_en) begin
      dspace_rd_q <= xd_rd && !sel_q;
      dspace_wr_q <= xd_wr && !sel_q;
      if ((xd_rd || xd_wr) && !sel_q) begin
        dspace_addr_q <= xd_addr;
        dspace_wdata_q <= xd_wdata;
      end
    end
  end

  ede_prog_timer #(
    .PRESCALE(PRESCALE)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .clk_en(clk_en),
    .prog(prog)
  );

  assign sfr_rdata = sfr_rdata_q;
  assign xd_rdata = xd_rdata_q;
  assign xd_rvalid = xd_rvalid_q;
  assign dspace_rd = dspace_rd_q;
  assign dspace_wr = dspace_wr_q;
  assign dspace_addr = dspace_addr_q;
  assign dspace_wdata = dspace_wdata_q;
  assign program_in_progress = busy_q;
  assign eeprom_space_select = sel_q;

  a_launch_busy: assert property (@(posedge clk) disable iff (rst)
    fire |=> busy_q ##0 program_in_progress)
    else $error("launch did not set busy");
  a_unarmed_noop: assert property (@(posedge clk) disable iff (rst)
    (ctl_wr && !armed_q && !busy_q) |=> !busy_q)
    else $error("busy set without armed launch");
  a_done_clear: assert property (@(posedge clk) disable iff (rst)
    commit |=> !busy_q)
    else $error("busy not cleared at end");
  a_busy_holds: assert property (@(posedge clk) disable iff (rst)
    (busy_q && ctl_wr && !commit) |=> busy_q)
    else $error("software changed busy");
  a_ee_read: assert property (@(posedge clk) disable iff (rst)
    (clk_en && xd_rd && sel_q && !busy_q) |=> xd_rvalid_q && xd_rdata_q == $past(rd_expect))
    else $error("eeprom read data wrong");
  a_busy_read: assert property (@(posedge clk) disable iff (rst)
    (clk_en && xd_rd && sel_q && busy_q) |=> xd_rdata_q == RD_BUSY_VAL)
    else $error("array read while busy");
  a_dspace_route: assert property (@(posedge clk) disable iff (rst)
    (clk_en && xd_wr && !sel_q) |=> dspace_wr_q && !$changed(lat_valid_q))
    else $error("data space write misrouted");
  a_page_drop: assert property (@(posedge clk) disable iff (rst)
    (ee_wr && page_held_q && !page_match && !commit) |=> $stable(lat_valid_q) && $stable(page_q))
    else $error("foreign page byte latched");
  a_reset_vals: assert property (@(posedge clk)
    rst |=> !sel_q && !busy_q && tim_q == TIM_RESET)
    else $error("reset values wrong");
  a_launch_gap: assert property (@(posedge clk) disable iff (rst)
    $rose(busy_q) |-> $past(ctl_wr) && $past(armed_q))
    else $error("busy rose without launch pair");

  c_launch: cover property (@(posedge clk) disable iff (rst) fire);
  c_finish: cover property (@(posedge clk) disable iff (rst) commit && lat_valid_q != '0);
  c_busy_read: cover property (@(posedge clk) disable iff (rst) clk_en && xd_rd && sel_q && busy_q);
  c_page_drop: cover property (@(posedge clk) disable iff (rst) ee_wr && page_held_q && !page_match);
endmodule
`default_nettype wire

/* ede_pkg.sv */
// constants shared by the data eeprom access control block
// assumes an 8-bit special function register bus and a 16-bit data pointer
package ede_pkg;
  localparam logic [7:0] ADDR_CTL = 8'hD2;      // eeprom_control
  localparam logic [7:0] ADDR_TIM = 8'hD3;      // eeprom_write_timer
  localparam int CTL_BUSY_BIT = 0;              // program_in_progress
  localparam int CTL_SEL_BIT = 1;               // eeprom_space_select
  localparam int LAUNCH_LSB = 4;                // program_launch_code lsb
  localparam logic [3:0] LAUNCH_ARM = 4'h5;
  localparam logic [3:0] LAUNCH_FIRE = 4'hA;
  localparam logic [7:0] TIM_RESET = 8'h00;
  localparam logic [7:0] RD_BUSY_VAL = 8'hFF;   // answer while the array is busy
  localparam logic [7:0] UNMAPPED_RD = 8'h00;
  localparam int TIM_W = 8;
  localparam int EE_BYTES = 2048;
  localparam int PAGE_BYTES = 64;
  localparam int PRESCALE_CYCLES = 256;         // clk cycles per write timer tick
  typedef enum logic [1:0] {
    EDE_IDLE = 2'b01,
    EDE_RUN = 2'b10
  } ede_tmr_state_e;
endpackage

/* ede_prog_if.sv */
// carrier between the eeprom control and its programming timer
// assumes both ends run on the same clock
`timescale 1ns/10ps
`default_nettype none
interface ede_prog_if;
  logic start;
  logic [ede_pkg::TIM_W-1:0] ticks;
  logic done;
  modport ctrl (output start, output ticks, input done);
  modport tmr (input start, input ticks, output done);
endinterface
`default_nettype wire

/* ede_prog_timer.sv */
// programming duration timer: prescaled down counter loaded from the write timer
// assumes start only arrives while idle
`timescale 1ns/10ps
`default_nettype none
module ede_prog_timer #(
  parameter int PRESCALE = ede_pkg::PRESCALE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  ede_prog_if.tmr prog
);
  import ede_pkg::*;
  localparam int PW = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;
  localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE - 1);

  ede_tmr_state_e state_q;
  logic [PW-1:0] pre_q;
  logic [TIM_W-1:0] remain_q;
  logic done_q;
  logic tick;

  assign tick = (pre_q == PRE_LAST);
  assign prog.done = done_q;

  // a zero load still runs one tick so the busy flag never sticks
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= EDE_IDLE;
      pre_q <= '0;
      remain_q <= '0;
      done_q <= 1'b0;
    end else if (clk_en) begin
      done_q <= 1'b0;
      unique case (state_q)
        EDE_IDLE: begin
          if (prog.start) begin
            state_q <= EDE_RUN;
            pre_q <= '0;
            remain_q <= (prog.ticks == '0) ? TIM_W'(1) : prog.ticks;
          end
        end
        EDE_RUN: begin
          if (tick) begin
            pre_q <= '0;
            if (remain_q == TIM_W'(1)) begin
              state_q <= EDE_IDLE;
              done_q <= 1'b1;
            end else begin
              remain_q <= remain_q - TIM_W'(1);
            end
          end else begin
            pre_q <= pre_q + PW'(1);
          end
        end
      endcase
    end
  end

  a_start_runs: assert property (@(posedge clk) disable iff (rst)
    (clk_en && prog.start && state_q == EDE_IDLE) |=> state_q == EDE_RUN)
    else $error("timer did not start");
  a_done_at_expiry: assert property (@(posedge clk) disable iff (rst)
    $rose(done_q) |-> $past(remain_q) == TIM_W'(1) && $past(tick) && state_q == EDE_IDLE)
    else $error("done without expiry");
endmodule
`default_nettype wire

/* ede_dummy_end.sv */
// intentionally minimal: no logic
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

/* ede_core_model.sv */
// processor core model: issues register accesses and external data moves
// assumes its tasks are entered 1 ns after a rising clk edge
`timescale 1ns/10ps
`default_nettype none
module ede_core_model (
  input wire logic clk,
  output logic [7:0] sfr_addr,
  output logic sfr_wr,
  output logic sfr_rd,
  output logic [7:0] sfr_wdata,
  output logic xd_rd,
  output logic xd_wr,
  output logic [15:0] xd_addr,
  output logic [7:0] xd_wdata
);
  import ede_pkg::*;
  // quiet bus at time zero
  initial begin
    {sfr_wr, sfr_rd, xd_rd, xd_wr} = 4'h0;
    {sfr_addr, sfr_wdata, xd_addr, xd_wdata} = 40'h0;
  end
  // one-cycle register access after an idle edge, so back-to-back calls never drive
  // a line twice in one step; released address and data show the inverse and strobes drop, so late sampling shows up
  task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 {sfr_addr, sfr_wdata, sfr_wr, sfr_rd} = {a, d, w, !w};
    @(posedge clk);
    #1 {sfr_addr, sfr_wdata, sfr_wr, sfr_rd} = {~a, ~d, 2'h0};
  endtask
  // one-cycle external data move through the data pointer, also after an idle edge;
  // the answer pulse still stands when the task returns
  task automatic xd(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 {xd_addr, xd_wdata, xd_wr, xd_rd} = {a, d, w, !w};
    @(posedge clk);
    #1 {xd_addr, xd_wdata, xd_wr, xd_rd} = {~a, ~d, 2'h0};
  endtask
  // launch pair, reserved bits left at zero
  task automatic launch(input logic sel);
    sfr(1'h1, ADDR_CTL, {LAUNCH_ARM, 2'h0, sel, 1'h0});
    sfr(1'h1, ADDR_CTL, {LAUNCH_FIRE, 2'h0, sel, 1'h0});
  endtask
  // timer load: five per crystal MHz, ten in double speed mode
  task automatic set_tim(input int mhz, input logic x2);
    sfr(1'h1, ADDR_TIM, 8'(mhz * (x2 ? 10 : 5)));
  endtask
endmodule
`default_nettype wire

/* data_eeprom_access_control_test.sv */
// self-checking bench for ede_ctrl, driven through the core model
// assumes ede_pkg, ede_prog_if and the design modules are compiled first
`timescale 1ns/10ps
`default_nettype none
module data_eeprom_access_control_test;
  import ede_pkg::*;
  localparam int P = 2; // short prescale keeps programming runs brief
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic clk_en = 1'h1;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, xd_wdata, xd_rdata, dspace_wdata;
  logic sfr_wr, sfr_rd, xd_rd, xd_wr, xd_rvalid, dspace_rd, dspace_wr, busy, sel;
  logic [15:0] xd_addr, dspace_addr, ra;
  int fails = 0;
  int n_compared = 0;
  int pg;
  int w;
  logic [7:0] mem [int];
  always #50 clk = ~clk;
  ede_core_model core (.clk(clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .xd_rd(xd_rd), .xd_wr(xd_wr), .xd_addr(xd_addr),
    .xd_wdata(xd_wdata));
  ede_ctrl #(.PRESCALE(P)) dut (.clk(clk), .rst(rst), .clk_en(clk_en),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .xd_rd(xd_rd), .xd_wr(xd_wr), .xd_addr(xd_addr),
    .xd_wdata(xd_wdata), .xd_rdata(xd_rdata), .xd_rvalid(xd_rvalid),
    .dspace_rd(dspace_rd), .dspace_wr(dspace_wr), .dspace_addr(dspace_addr),
    .dspace_wdata(dspace_wdata), .program_in_progress(busy), .eeprom_space_select(sel));
  task automatic end_sim;
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // expected control read: reserved bits read as zero
  function automatic logic [7:0] exp_ctl(input logic s);
    return {6'h00, s, 1'h0};
  endfunction
  // a zero timer still runs one tick
  function automatic int exp_ticks(input logic [7:0] t);
    return (t == 8'h00 ? 1 : int'(t)) * P;
  endfunction
  task automatic rd_sfr(input logic [7:0] a, input logic [7:0] e);
    core.sfr(1'h0, a, 8'h00);
    chk8(sfr_rdata, e);
  endtask
  task automatic rd_xd(input logic [15:0] a, input logic [7:0] e);
    core.xd(1'h0, a, 8'h00);
    chk8({7'h00, xd_rvalid}, 8'h01);
    chk8(xd_rdata, e);
  endtask
  // write n bytes of one page, add a stray byte for the next page, launch and time the run
  task automatic prog(input int p, input int n, input int mhz, input logic x2);
    logic [7:0] d;
    logic [7:0] t;
    int cnt;
    t = 8'(mhz * (x2 ? 10 : 5));
    core.set_tim(mhz, x2);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      core.xd(1'h1, 16'(p * PAGE_BYTES + i), d);
      mem[p * PAGE_BYTES + i] = d;
    end
    core.xd(1'h1, 16'(((p + 1) % 32) * PAGE_BYTES), 8'h5A);
    core.launch(1'h1);
    chk8({7'h00, busy}, 8'h01);
    rd_xd(16'(p * PAGE_BYTES), RD_BUSY_VAL);
    core.sfr(1'h1, ADDR_CTL, 8'h03);
    chk8({7'h00, busy}, 8'h01);
    cnt = 4; // after the launch edge, busy read and control write each take two edges
    while (busy === 1'h1 && cnt < 3000) begin
      @(posedge clk);
      #1 cnt++;
    end
    if (cnt >= 3000) begin
      fails++;
      end_sim();
    end
    chk8({7'h00, cnt >= exp_ticks(t) - P && cnt <= exp_ticks(t) + 4}, 8'h01);
    foreach (mem[a]) rd_xd(16'(a), mem[a]);
  endtask
  initial begin
    void'($urandom(70189));
    repeat (5) @(posedge clk);
    #1 rst = 1'h0;
    rd_sfr(ADDR_CTL, exp_ctl(1'h0));
    rd_sfr(ADDR_TIM, TIM_RESET);
    rd_sfr(8'h00, UNMAPPED_RD);
    // a strobe with the clock enable low must be ignored
    clk_en = 1'h0;
    core.sfr(1'h1, ADDR_TIM, 8'h77);
    clk_en = 1'h1;
    rd_sfr(ADDR_TIM, TIM_RESET);
    core.sfr(1'h1, ADDR_CTL, 8'h03);
    rd_sfr(ADDR_CTL, exp_ctl(1'h1));
    core.sfr(1'h1, ADDR_CTL, 8'h00);
    ra = 16'($urandom);
    core.xd(1'h1, ra, 8'hC3);
    chk8({dspace_wr, dspace_rd, xd_rvalid, 5'h00}, 8'h80);
    chk8(dspace_wdata, 8'hC3);
    chk8(dspace_addr[15:8], ra[15:8]);
    chk8(dspace_addr[7:0], ra[7:0]);
    core.xd(1'h0, ra, 8'h00);
    chk8({dspace_wr, dspace_rd, xd_rvalid, 5'h00}, 8'h40);
    // fire code alone, then a broken pair
    core.sfr(1'h1, ADDR_CTL, 8'hA2);
    chk8({7'h00, busy}, 8'h00);
    core.sfr(1'h1, ADDR_CTL, 8'h52);
    core.sfr(1'h1, ADDR_CTL, 8'h02);
    core.sfr(1'h1, ADDR_CTL, 8'hA2);
    chk8({6'h00, sel, busy}, 8'h02);
    pg = $urandom_range(30);
    prog(pg + 1, PAGE_BYTES, 1, 1'h0);
    prog(pg, $urandom_range(64, 1), $urandom_range(4, 1), 1'h1);
    // pair with select clear still launches, even with no latched bytes
    core.launch(1'h0);
    chk8({6'h00, sel, busy}, 8'h01);
    w = 0;
    while (busy === 1'h1 && w < 3000) begin
      @(posedge clk);
      #1 w++;
    end
    chk8({6'h00, sel, busy}, 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
